// ---- hdl/sdmc_map.svh ----
// Purpose: Constants for the sensor diagnostics and mode control block
// Assumes: core_clk at 40 MHz (25 ns)
// Notes:   Times kept in their own units; cycle counts derived from them
`ifndef SDMC_MAP_SVH
`define SDMC_MAP_SVH

`define SDMC_CLK_HZ          40000000
// Times as printed
`define SDMC_CMD_WIN_US      3000
`define SDMC_SIG_LIMIT_US    10000
`define SDMC_BRIDGE_LIMIT_US 2000
`define SDMC_SHORT_PULL_US   4
`define SDMC_RECOVER_US      480
// Cycle counts: least times round up, longest round down
`define SDMC_CMD_WIN_CYC     ((`SDMC_CMD_WIN_US * (`SDMC_CLK_HZ / 1000000)))
`define SDMC_SIG_LIMIT_CYC   ((`SDMC_SIG_LIMIT_US * (`SDMC_CLK_HZ / 1000000)))
// Scaled through kHz so the products stay inside 32 bits
`define SDMC_SHORT_PULL_CYC  ((`SDMC_SHORT_PULL_US * (`SDMC_CLK_HZ / 1000) + 999) / 1000)
`define SDMC_RECOVER_CYC     ((`SDMC_RECOVER_US * (`SDMC_CLK_HZ / 1000) + 999) / 1000)
// Lock field values
`define SDMC_LOCK_A          3'h3
`define SDMC_LOCK_B          3'h6
// Output mode codes
`define SDMC_OUT_RATIO       2'h0
`define SDMC_OUT_DIGITAL     2'h1
`define SDMC_OUT_ABS         2'h2
// Diagnostic level codes
`define SDMC_DIAG_NONE       2'h0
`define SDMC_DIAG_LOW        2'h1
`define SDMC_DIAG_HIGH       2'h2
// Signature seed and feedback taps
`define SDMC_SIG_SEED        8'hff
`define SDMC_SIG_TAPS        8'h1d

`endif

// ---- hdl/sdmc_pkg.sv ----
// Purpose: Types for the sensor diagnostics and mode control block
// Assumes: Nothing beyond the map header
// Notes:   States only; numbers live in sdmc_map.svh
package sdmc_pkg;
    typedef enum logic [2:0] {
        SDMC_MODE_SIGCHK,
        SDMC_MODE_WINDOW,
        SDMC_MODE_NORMAL,
        SDMC_MODE_COMMAND,
        SDMC_MODE_RAW
    } sdmc_mode_t;

    typedef enum logic [1:0] {
        SDMC_BR_IDLE,
        SDMC_BR_PULL,
        SDMC_BR_RECOVER
    } sdmc_bridge_t;
endpackage

// ---- hdl/sdmc_top.sv ----
// Purpose: Start-up mode sequencing and fault monitoring for a bridge sensor conditioner
// Assumes: Memory words are read one per cycle; comparators and frame coder sit outside
// Notes:   All outputs registered; comparators pass a three-flop filter, other inputs are used unsynchronised
//
// Summary of operation
// - Ratiometric analog output signals faults below 2.5% or above 97.5% supply.
// - Digital output signals faults with a deliberately wrong parity bit.
// - Absolute low-voltage analog mode reports no diagnostic states.
// - Calibration memory carries an 8-bit LFSR signature, renewed on each change.
// - After reset recompute signature; mismatch gives lower level within 10 ms.
// - Lock field 011 or 110 kills charge pump and all further writes.
// - Four comparators keep both bridge inputs between 0.8 V and 0.85 supply.
// - Each bridge input has a switched path to ground for floating detection (code holds one bridge_discharge_en at 1).
// - Supply, open or short bridge faults give upper level within 2 ms.
// - With short check on, pull positive input low 4 us after measurement.
// - If negative input also fell below 0.8 V then, declare a short.
// - Allow at least 480 us bridge recovery before the next measurement.
// - Power or ground loss diagnosis works only in analog output mode.
// - Listen 3 ms after power-on for the command-mode entry command.
// - Without entry, run normal operation with output form from configuration.
// - Command mode entered only inside the window and held until a raw-mode command.
// - Raw-mode command from command mode streams uncorrected values in order.
// - Raw mode is left only by power removal.
// - Faults reach the output only when diagnostics are enabled.
// - Pin pull-up on during digital output mode and the command window.
`timescale 1ns/1ps
`include "sdmc_map.svh"

module sdmc_top
    import sdmc_pkg::*;
#(
    parameter int MEM_WORDS      = 16,
    parameter int CMD_WIN_CYC    = `SDMC_CMD_WIN_CYC,
    parameter int SIG_LIMIT_CYC  = `SDMC_SIG_LIMIT_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Calibration memory read port and configuration
    output logic [3:0]       mem_rd_addr,
    input  wire logic [7:0]  mem_rd_data,
    input  wire logic [7:0]  stored_signature,
    input  wire logic [2:0]  lock_field,
    input  wire logic [1:0]  out_mode_cfg,
    input  wire logic        diag_enable_cfg,
    input  wire logic        short_check_cfg,
    // Memory write requests from the command path
    input  wire logic        mem_wr_req,
    output logic             mem_wr_grant,
    output logic             charge_pump_en,
    output logic             sig_regen_req,
    // Commands decoded from the one-wire pin
    input  wire logic        enter_command_mode_cmd,
    input  wire logic        enter_raw_mode_cmd,
    // Bridge comparators (asynchronous)
    input  wire logic        bp_below_low,
    input  wire logic        bp_above_high,
    input  wire logic        bn_below_low,
    input  wire logic        bn_above_high,
    input  wire logic        meas_done,
    output logic             meas_allow,
    output logic             bp_pull_low,
    output logic             bridge_discharge_en,
    // Mode and output
    output logic             normal_operation_mode,
    output logic             command_mode_state,
    output logic             raw_mode_state,
    output logic [1:0]       diag_level,
    output logic             parity_invert,
    output logic             pin_pullup_en
);

    // ==========================================================
    // Comparator synchronisers
    // ==========================================================
    logic [3:0] cmp_s1_q;
    logic [3:0] cmp_s2_q;
    logic [3:0] cmp_s3_q;
    logic [3:0] cmp_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmp_s1_q <= 4'h0;
            cmp_s2_q <= 4'h0;
            cmp_s3_q <= 4'h0;
            cmp_q    <= 4'h0;
        end else begin
            cmp_s1_q <= {bn_above_high, bn_below_low, bp_above_high, bp_below_low};
            cmp_s2_q <= cmp_s1_q;
            cmp_s3_q <= cmp_s2_q;
            for (int i = 0; i < 4; i++) begin
                if (cmp_s2_q[i] == cmp_s3_q[i]) begin
                    cmp_q[i] <= cmp_s3_q[i];
                end
            end
        end
    end

    logic bp_low;
    logic bn_low;
    logic range_fault;
    assign bp_low      = cmp_q[0];
    assign bn_low      = cmp_q[2];
    assign range_fault = |cmp_q;

    // ==========================================================
    // Signature check after reset
    // ==========================================================
    localparam int CNT_W = $clog2(CMD_WIN_CYC + SIG_LIMIT_CYC + 2);

    sdmc_mode_t mode_q;
    logic [CNT_W-1:0] win_cnt_q;
    logic [4:0]       sig_idx_q;
    logic [7:0]       sig_q;
    logic             sig_done_q;
    logic             sig_fail_q;
    logic [7:0]       sig_next;

    always_comb begin
        sig_next = {sig_q[6:0], 1'b0} ^ mem_rd_data;
        if (sig_q[7]) begin
            sig_next = sig_next ^ `SDMC_SIG_TAPS;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sig_idx_q  <= 5'h00;
            sig_q      <= `SDMC_SIG_SEED;
            sig_done_q <= 1'b0;
            sig_fail_q <= 1'b0;
        end else if (!sig_done_q) begin
            sig_q     <= sig_next;
            sig_idx_q <= sig_idx_q + 5'h01;
            if (sig_idx_q == 5'(MEM_WORDS - 1)) begin
                sig_done_q <= 1'b1;
                sig_fail_q <= (sig_next != stored_signature);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mem_rd_addr <= 4'h0;
        end else begin
            mem_rd_addr <= 4'(sig_idx_q + 5'h01);
        end
    end

    // ==========================================================
    // Memory write lock
    // ==========================================================
    logic locked;
    assign locked = (lock_field == `SDMC_LOCK_A) || (lock_field == `SDMC_LOCK_B);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mem_wr_grant   <= 1'b0;
            charge_pump_en <= 1'b0;
            sig_regen_req  <= 1'b0;
        end else begin
            mem_wr_grant   <= mem_wr_req && !locked && command_mode_state;
            charge_pump_en <= mem_wr_req && !locked && command_mode_state;
            sig_regen_req  <= mem_wr_grant;
        end
    end

    // ==========================================================
    // Start-up mode sequencing
    // ==========================================================
    logic in_window;
    assign in_window = (mode_q == SDMC_MODE_SIGCHK) || (mode_q == SDMC_MODE_WINDOW);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_q    <= SDMC_MODE_SIGCHK;
            win_cnt_q <= '0;
        end else begin
            if (in_window) begin
                win_cnt_q <= win_cnt_q + 1'b1;
            end
            case (mode_q)
                SDMC_MODE_SIGCHK, SDMC_MODE_WINDOW: begin
                    if (enter_command_mode_cmd) begin
                        mode_q <= SDMC_MODE_COMMAND;
                    end else if (win_cnt_q >= CNT_W'(CMD_WIN_CYC - 1) && sig_done_q) begin
                        mode_q <= SDMC_MODE_NORMAL;
                    end else if (sig_done_q) begin
                        mode_q <= SDMC_MODE_WINDOW;
                    end
                end
                SDMC_MODE_COMMAND: begin
                    if (enter_raw_mode_cmd) begin
                        mode_q <= SDMC_MODE_RAW;
                    end
                end
                SDMC_MODE_NORMAL: begin
                    mode_q <= SDMC_MODE_NORMAL;
                end
                SDMC_MODE_RAW: begin
                    mode_q <= SDMC_MODE_RAW;
                end
                default: begin
                    mode_q <= SDMC_MODE_SIGCHK;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            normal_operation_mode <= 1'b0;
            command_mode_state    <= 1'b0;
            raw_mode_state        <= 1'b0;
            pin_pullup_en         <= 1'b1;
        end else begin
            normal_operation_mode <= (mode_q == SDMC_MODE_NORMAL);
            command_mode_state    <= (mode_q == SDMC_MODE_COMMAND);
            raw_mode_state        <= (mode_q == SDMC_MODE_RAW);
            pin_pullup_en         <= in_window || (mode_q == SDMC_MODE_COMMAND)
                                     || (out_mode_cfg == `SDMC_OUT_DIGITAL)
                                     || (mode_q == SDMC_MODE_RAW);
        end
    end

    // ==========================================================
    // Bridge short check and recovery
    // ==========================================================
    localparam int BR_W = $clog2(`SDMC_RECOVER_CYC + 2);

    sdmc_bridge_t    br_q;
    logic [BR_W-1:0] br_cnt_q;
    logic            short_fault_q;
    logic            range_fault_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            br_q          <= SDMC_BR_IDLE;
            br_cnt_q      <= '0;
            short_fault_q <= 1'b0;
        end else begin
            case (br_q)
                SDMC_BR_IDLE: begin
                    br_cnt_q <= '0;
                    if (meas_done && short_check_cfg) begin
                        br_q <= SDMC_BR_PULL;
                    end
                end
                SDMC_BR_PULL: begin
                    br_cnt_q <= br_cnt_q + 1'b1;
                    if (br_cnt_q == BR_W'(`SDMC_SHORT_PULL_CYC - 1)) begin
                        short_fault_q <= bp_low && bn_low;
                        br_cnt_q      <= '0;
                        br_q          <= SDMC_BR_RECOVER;
                    end
                end
                SDMC_BR_RECOVER: begin
                    br_cnt_q <= br_cnt_q + 1'b1;
                    if (br_cnt_q == BR_W'(`SDMC_RECOVER_CYC - 1)) begin
                        br_q <= SDMC_BR_IDLE;
                    end
                end
                default: begin
                    br_q <= SDMC_BR_IDLE;
                end
            endcase
        end
    end

    // Range faults are sampled once per conversion, outside the forced pull-down
    always_ff @(posedge core_clk) begin
        if (rst) begin
            range_fault_q <= 1'b0;
        end else if (meas_done) begin
            range_fault_q <= range_fault;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            bp_pull_low         <= 1'b0;
            meas_allow          <= 1'b0;
            bridge_discharge_en <= 1'b0;
        end else begin
            bp_pull_low         <= (br_q == SDMC_BR_PULL);
            meas_allow          <= (br_q == SDMC_BR_IDLE) && !meas_done;
            bridge_discharge_en <= 1'b1;
        end
    end

    // ==========================================================
    // Diagnostic output
    // ==========================================================
    logic upper_fault;
    logic lower_fault;
    logic report;
    assign upper_fault = range_fault_q || short_fault_q;
    assign lower_fault = sig_done_q && sig_fail_q;
    assign report      = diag_enable_cfg && (out_mode_cfg != `SDMC_OUT_ABS)
                         && (mode_q == SDMC_MODE_NORMAL);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            diag_level    <= `SDMC_DIAG_NONE;
            parity_invert <= 1'b0;
        end else begin
            diag_level    <= `SDMC_DIAG_NONE;
            parity_invert <= 1'b0;
            if (report && (lower_fault || upper_fault)) begin
                if (out_mode_cfg == `SDMC_OUT_DIGITAL) begin
                    parity_invert <= 1'b1;
                end else if (lower_fault) begin
                    diag_level <= `SDMC_DIAG_LOW;
                end else begin
                    diag_level <= `SDMC_DIAG_HIGH;
                end
            end
        end
    end

endmodule

// ---- sim/sdmc_cal_master.sv ----
// Purpose: Calibration master on the one-wire pin, as decoded commands
// Assumes: Bench requests one command at a time
// Notes:   lag sets how slowly the master answers a request
`timescale 1ns/1ps
module sdmc_cal_master (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       send_cm,
    input  wire logic       send_rm,
    input  wire logic [7:0] lag,
    output logic            enter_command_mode_cmd,
    output logic            enter_raw_mode_cmd
);
    logic [7:0] cnt_q;
    logic       busy_q;
    logic       raw_q;
    always_ff @(posedge core_clk) begin
        enter_command_mode_cmd <= 1'b0;
        enter_raw_mode_cmd <= 1'b0;
        if (rst) begin
            busy_q <= 1'b0;
        end else if (send_cm || send_rm) begin
            busy_q <= 1'b1;
            raw_q <= send_rm;
            cnt_q <= lag;
        end else if (busy_q && cnt_q == 8'h00) begin
            busy_q <= 1'b0;
            enter_command_mode_cmd <= !raw_q;
            enter_raw_mode_cmd <= raw_q;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule

// ---- sim/sdmc_checker_assertions.sv ----
// Purpose: Port-level assertions for sdmc_top
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound to sdmc_top from the bench top file
`timescale 1ns/1ps
`include "sdmc_map.svh"
module sdmc_checker (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [2:0] lock_field,
    input wire logic [1:0] out_mode_cfg,
    input wire logic       diag_enable_cfg,
    input wire logic       mem_wr_grant,
    input wire logic       charge_pump_en,
    input wire logic       sig_regen_req,
    input wire logic       enter_command_mode_cmd,
    input wire logic       bp_pull_low,
    input wire logic       meas_allow,
    input wire logic       normal_operation_mode,
    input wire logic       command_mode_state,
    input wire logic       raw_mode_state,
    input wire logic [1:0] diag_level,
    input wire logic       parity_invert,
    input wire logic       pin_pullup_en
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Pull width and recovery counters
    logic [7:0]  pull_q;
    logic [15:0] since_q;
    always_ff @(posedge core_clk) begin
        if (rst || !bp_pull_low) pull_q <= 8'h00;
        else pull_q <= pull_q + 8'h01;
    end
    always_ff @(posedge core_clk) begin
        if (rst) since_q <= 16'hffff;
        else if (bp_pull_low) since_q <= 16'h0000;
        else if (since_q != 16'hffff) since_q <= since_q + 16'h0001;
    end
    // ==========================================
    // Assertions
    a_lock_blocks_wr: assert property ((lock_field == `SDMC_LOCK_A || lock_field == `SDMC_LOCK_B)
        |=> !mem_wr_grant && !charge_pump_en) else $error("write granted while locked");
    a_regen_follows: assert property (mem_wr_grant |=> sig_regen_req)
        else $error("no signature renewal after write");
    a_raw_held: assert property (raw_mode_state |=> raw_mode_state)
        else $error("raw mode left");
    a_normal_held: assert property (normal_operation_mode |=> normal_operation_mode && !command_mode_state)
        else $error("normal mode left");
    a_cmd_entry_cause: assert property ($rose(command_mode_state) |-> $past(enter_command_mode_cmd, 2))
        else $error("command mode without entry command");
    a_raw_from_cmd: assert property ($rose(raw_mode_state) |-> $past(command_mode_state))
        else $error("raw mode not from command mode");
    a_abs_silent: assert property ((out_mode_cfg == `SDMC_OUT_ABS) [*3]
        |-> diag_level == `SDMC_DIAG_NONE && !parity_invert) else $error("fault shown in absolute mode");
    a_diag_off_quiet: assert property ((!diag_enable_cfg) [*3]
        |-> diag_level == `SDMC_DIAG_NONE && !parity_invert) else $error("fault shown while disabled");
    a_pull_width: assert property ($fell(bp_pull_low) |-> pull_q == `SDMC_SHORT_PULL_CYC)
        else $error("short pull width wrong");
    a_recovery_min: assert property ($rose(meas_allow) |-> since_q >= `SDMC_RECOVER_CYC - 2)
        else $error("recovery too short");
    a_pullup_digital: assert property ((normal_operation_mode && out_mode_cfg == `SDMC_OUT_DIGITAL) [*2]
        |-> pin_pullup_en) else $error("pull-up off in digital mode");
endmodule

// ---- sim/sdmc_top_tb_top.sv ----
// Purpose: Self-checking bench for sdmc_top
// Assumes: Command window shortened to 200 cycles
// Notes:   Bridge comparators modelled from the pull output and the flt fault vector
`timescale 1ns/1ps
`include "sdmc_map.svh"
module sdmc_top_tb_top;
    import sdmc_pkg::*;
    localparam int CW = 200;
    logic core_clk, rst, mem_wr_req, diag_enable_cfg, short_check_cfg, meas_done, send_cm, send_rm;
    logic mem_wr_grant, charge_pump_en, sig_regen_req, enter_command_mode_cmd, enter_raw_mode_cmd;
    logic bp_below_low, bp_above_high, bn_below_low, bn_above_high, meas_allow, bp_pull_low;
    logic bridge_discharge_en, normal_operation_mode, command_mode_state, raw_mode_state;
    logic parity_invert, pin_pullup_en, short_q;
    logic [3:0] mem_rd_addr, flt;
    logic [7:0] mem_rd_data, stored_signature, lag, good_sig;
    logic [7:0] mem [16];
    logic [2:0] lock_field;
    logic [1:0] out_mode_cfg, diag_level;
    int error_cnt, n_compared;
    // ==========================================
    // Memory and bridge models
    assign mem_rd_data = mem[mem_rd_addr];
    assign bp_below_low = bp_pull_low | flt[0];
    assign bp_above_high = flt[1];
    assign bn_below_low = (short_q & bp_pull_low) | flt[2];
    assign bn_above_high = flt[3];
    sdmc_top #(.MEM_WORDS(16), .CMD_WIN_CYC(CW), .SIG_LIMIT_CYC(`SDMC_SIG_LIMIT_CYC)) sdmc_top_inst (
        .core_clk, .rst, .mem_rd_addr, .mem_rd_data, .stored_signature, .lock_field, .out_mode_cfg,
        .diag_enable_cfg, .short_check_cfg, .mem_wr_req, .mem_wr_grant, .charge_pump_en, .sig_regen_req,
        .enter_command_mode_cmd, .enter_raw_mode_cmd, .bp_below_low, .bp_above_high, .bn_below_low,
        .bn_above_high, .meas_done, .meas_allow, .bp_pull_low, .bridge_discharge_en, .normal_operation_mode,
        .command_mode_state, .raw_mode_state, .diag_level, .parity_invert, .pin_pullup_en);
    sdmc_cal_master sdmc_cal_master_inst (.core_clk, .rst, .send_cm, .send_rm, .lag,
        .enter_command_mode_cmd, .enter_raw_mode_cmd);
    // ==========================================
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic boot(input logic [7:0] sig, input logic [1:0] md, input logic en);
        cyc(1);
        stored_signature <= sig;
        out_mode_cfg <= md;
        diag_enable_cfg <= en;
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
    endtask
    task automatic cmd(input logic raw, input logic [7:0] l);
        cyc(1);
        send_cm <= !raw;
        send_rm <= raw;
        lag <= l;
        cyc(1);
        send_cm <= 1'b0;
        send_rm <= 1'b0;
        cyc(int'(l) + 4);
        @(negedge core_clk);
    endtask
    task automatic meas_chk(input logic [3:0] f, input logic [1:0] exp);
        cyc(1);
        flt <= f;
        cyc(6);
        meas_done <= 1'b1;
        cyc(1);
        meas_done <= 1'b0;
        cyc(6);
        @(negedge core_clk);
        chk(diag_level, exp);
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_sig_scan();
        int hits = 0;
        for (int s = 0; s < 256; s++) begin
            boot(8'(s), `SDMC_OUT_RATIO, 1'b1);
            cyc(CW + 20);
            @(negedge core_clk);
            chk(normal_operation_mode, 1'b1);
            if (diag_level === `SDMC_DIAG_NONE) good_sig = 8'(s);
            if (diag_level === `SDMC_DIAG_NONE) hits++;
            else chk(diag_level, `SDMC_DIAG_LOW);
        end
        chk(8'(hits), 8'h01);
        $display("test sig_scan done");
    endtask
    task automatic t_out_table();
        for (int i = 0; i < 4; i++) begin
            boot(good_sig ^ 8'h01, (i == 3) ? `SDMC_OUT_RATIO : 2'(i), i != 3);
            cyc(CW + 20);
            @(negedge core_clk);
            chk(parity_invert, i == 1);
            chk(pin_pullup_en, i == 1);
            if (i != 1) chk(diag_level, (i == 0) ? `SDMC_DIAG_LOW : `SDMC_DIAG_NONE);
        end
        $display("test out_table done");
    endtask
    task automatic t_modes();
        boot(good_sig, `SDMC_OUT_RATIO, 1'b1);
        @(negedge core_clk);
        chk(pin_pullup_en, 1'b1);
        cmd(1'b0, 8'h32);
        chk(pin_pullup_en, 1'b1);
        chk(command_mode_state, 1'b1);
        for (int k = 0; k < 3; k++) begin
            cyc(1);
            lock_field <= (k == 0) ? 3'h0 : (k == 1) ? `SDMC_LOCK_A : `SDMC_LOCK_B;
            mem_wr_req <= 1'b1;
            cyc(3);
            @(negedge core_clk);
            chk(mem_wr_grant, k == 0);
            chk(charge_pump_en, k == 0);
            chk(sig_regen_req, k == 0);
        end
        cyc(1);
        mem_wr_req <= 1'b0;
        cyc(CW);
        cmd(1'b1, 8'h00);
        chk(raw_mode_state, 1'b1);
        cmd(1'b0, 8'h00);
        chk(raw_mode_state, 1'b1);
        boot(good_sig, `SDMC_OUT_RATIO, 1'b1);
        cyc(CW + 20);
        cmd(1'b0, 8'h00);
        chk(command_mode_state, 1'b0);
        cmd(1'b1, 8'h00);
        chk(raw_mode_state, 1'b0);
        $display("test modes done");
    endtask
    task automatic t_bridge();
        int n = 0;
        boot(good_sig, `SDMC_OUT_RATIO, 1'b1);
        cyc(CW - 10);
        @(negedge core_clk);
        chk(normal_operation_mode, 1'b0);
        cyc(30);
        @(negedge core_clk);
        chk(normal_operation_mode, 1'b1);
        chk(bridge_discharge_en, 1'b1);
        for (int j = 0; j < 4; j++) begin
            meas_chk(4'h1 << j, `SDMC_DIAG_HIGH);
            meas_chk(4'h0, `SDMC_DIAG_NONE);
        end
        cyc(1);
        short_check_cfg <= 1'b1;
        short_q <= 1'b1;
        meas_done <= 1'b1;
        cyc(1);
        meas_done <= 1'b0;
        while (bp_pull_low !== 1'b1 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        n = 0;
        while (bp_pull_low === 1'b1 && n < 255) begin
            @(negedge core_clk);
            n++;
        end
        chk(8'(n), 8'(`SDMC_SHORT_PULL_CYC));
        n = 0;
        while (meas_allow !== 1'b1 && n < 25000) begin
            @(negedge core_clk);
            n++;
        end
        chk(n >= `SDMC_RECOVER_CYC - 2 && n < 25000, 1'b1);
        chk(diag_level, `SDMC_DIAG_HIGH);
        $display("test bridge done");
    endtask
    // ==========================================
    // Clock, watchdog, main sequence
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        // Expected run is near 2 ms
        #2400000;
        error_cnt++;
        results();
    end
    initial begin
        {rst, mem_wr_req, diag_enable_cfg, short_check_cfg, meas_done, send_cm, send_rm, short_q} = 8'h80;
        {flt, lag, stored_signature, lock_field, out_mode_cfg, good_sig} = '0;
        error_cnt = 0;
        n_compared = 0;
        for (int i = 0; i < 16; i++) mem[i] = 8'(i * 37 + 5);
        cyc(16);
        rst <= 1'b0;
        t_sig_scan();
        t_out_table();
        t_modes();
        t_bridge();
        results();
    end
endmodule
bind sdmc_top sdmc_checker sdmc_checker_inst (.core_clk, .rst, .lock_field, .out_mode_cfg, .diag_enable_cfg,
    .mem_wr_grant, .charge_pump_en, .sig_regen_req, .enter_command_mode_cmd, .bp_pull_low, .meas_allow,
    .normal_operation_mode, .command_mode_state, .raw_mode_state, .diag_level, .parity_invert, .pin_pullup_en);
